// ### src/pdp_pkg.sv
// Constants, register map and lookup tables of the playback digital path.
// Assumes a 100 MHz ref_clk and one playback sample per frame from the audio interface.
package pdp_pkg;
  // Register addresses of the control port.
  localparam logic [6:0] PDP_ADDR_POWER_ONE = 7'h03;
  localparam logic [6:0] PDP_ADDR_CONTROL = 7'h0A;
  localparam logic [6:0] PDP_ADDR_VOLUME = 7'h0B;
  localparam logic [6:0] PDP_ADDR_LIM_ONE = 7'h18;
  localparam logic [6:0] PDP_ADDR_LIM_TWO = 7'h19;
  // Field positions.
  localparam int PDP_ENABLE_BIT = 0;
  localparam int PDP_POLARITY_BIT = 0;
  localparam int PDP_AUTOMUTE_BIT = 2;
  localparam int PDP_SOFT_MUTE_BIT = 6;
  localparam int PDP_LIM_ENABLE_BIT = 8;
  localparam int PDP_DCY_LSB = 4;
  localparam int PDP_ATK_LSB = 0;
  localparam int PDP_LVL_LSB = 4;
  localparam int PDP_BOOST_LSB = 0;
  // Reset values.
  localparam logic [7:0] PDP_VOL_RESET = 8'hFF;
  localparam logic [3:0] PDP_DCY_RESET = 4'h3;
  localparam logic [3:0] PDP_ATK_RESET = 4'h2;
  localparam logic [2:0] PDP_LVL_RESET = 3'h0;
  localparam logic [3:0] PDP_BOOST_RESET = 4'h0;
  // Sample stream and auto mute.
  localparam logic [4:0] PDP_SAMPLE_LAST_BIT = 5'h17;
  localparam logic [10:0] PDP_ZERO_RUN = 11'h400;
  // Code limits; higher codes alias to these.
  localparam logic [3:0] PDP_BOOST_MAX = 4'hC;
  localparam logic [3:0] PDP_RATE_CODE_MAX = 4'hB;
  localparam logic [2:0] PDP_LVL_CODE_MAX = 3'h5;
  // Limiter attenuation: half-dB steps with 12 fraction bits, capped at 24 dB.
  localparam int PDP_LIM_FRAC_BITS = 12;
  localparam logic [17:0] PDP_LIM_ATT_MAX = 18'h30000;
  localparam longint PDP_LIM_ATK_TIME_NS = 94000;
  localparam longint PDP_LIM_DCY_TIME_NS = 750000;
  localparam longint PDP_REF_FS_HZ = 44100;
  localparam longint PDP_STEPS_PER_6DB = 12;
  localparam logic [17:0] PDP_LIM_ATK_RATE = 18'(PDP_STEPS_PER_6DB *
    (longint'(1) << PDP_LIM_FRAC_BITS) * 1000000000 / (PDP_LIM_ATK_TIME_NS * PDP_REF_FS_HZ));
  localparam logic [17:0] PDP_LIM_DCY_RATE = 18'(PDP_STEPS_PER_6DB *
    (longint'(1) << PDP_LIM_FRAC_BITS) * 1000000000 / (PDP_LIM_DCY_TIME_NS * PDP_REF_FS_HZ));
  // Gain index: half-dB attenuation plus 24 so that full boost stays non-negative.
  localparam logic [9:0] PDP_GAIN_OFFSET = 10'h117;
  localparam logic [9:0] PDP_STEPS_PER_SHIFT = 10'h00C;
  localparam logic [5:0] PDP_GAIN_SHIFT_BASE = 6'h0D;
  // Oversampling of the interpolator and modulator idle code.
  localparam int PDP_OSR_LOG2 = 6;
  localparam logic [6:0] PDP_OSR = 7'h40;
  localparam logic [4:0] PDP_DAC_MID = 5'h08;
  // Q15 mantissas of 10^(-k/40), one half-dB apart.
  localparam logic [15:0] PDP_MANT [12] = '{16'h8000, 16'h78D7, 16'h7215, 16'h6BB3,
    16'h65AD, 16'h5FFD, 16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};
  // Full-scale magnitudes at -0.5, -1.5 ... -6.5 dB for the two limiter thresholds.
  localparam logic [23:0] PDP_LIM_THR [7] = '{24'h78D7F8, 24'h6BB2DC, 24'h5FFC86,
    24'h558C46, 24'h4C3E98, 24'h43F40E, 24'h3C8C99};
endpackage

// ### src/pdp_playback_path.sv
// Playback digital path: volume, soft mute, limiter, polarity, auto mute,
// interpolation and multi-bit sigma-delta modulation.
// Assumes oversample_tick pulses 64 times per sample period from the clock manager.
`timescale 1ns/100ps
`default_nettype none
module pdp_playback_path
  import pdp_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Register port.
  input wire logic reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  // Audio interface.
  input wire logic frame_start,
  input wire logic bit_valid,
  input wire logic playback_serial_data,
  // Converter side.
  input wire logic oversample_tick,
  output logic [4:0] dac_level,
  output logic path_running,
  output logic zero_run_muted,
  output logic limiter_active
);
  logic playback_enable, output_polarity_invert, zero_run_mute_enable, soft_mute_bit;
  logic limiter_enable, rx_valid, a_valid, out_valid;
  logic [7:0] playback_volume_code, cur_vol;
  logic [3:0] limiter_decay_code, limiter_attack_code, limiter_boost_code;
  logic [2:0] limiter_threshold_code;
  logic [23:0] rx_sample, x_reg, out_sample;
  logic [10:0] zero_cnt;
  logic [17:0] lim_att;
  logic [29:0] interp, interp_step;
  logic [6:0] step_cnt;
  logic [19:0] sd_err;

  // Register writes; all fields come up in their documented reset state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      playback_enable <= 1'b0;
      output_polarity_invert <= 1'b0;
      zero_run_mute_enable <= 1'b0;
      soft_mute_bit <= 1'b0;
      playback_volume_code <= PDP_VOL_RESET;
      limiter_enable <= 1'b0;
      limiter_decay_code <= PDP_DCY_RESET;
      limiter_attack_code <= PDP_ATK_RESET;
      limiter_threshold_code <= PDP_LVL_RESET;
      limiter_boost_code <= PDP_BOOST_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        PDP_ADDR_POWER_ONE: playback_enable <= reg_wdata[PDP_ENABLE_BIT];
        PDP_ADDR_CONTROL: begin
          soft_mute_bit <= reg_wdata[PDP_SOFT_MUTE_BIT];
          zero_run_mute_enable <= reg_wdata[PDP_AUTOMUTE_BIT];
          output_polarity_invert <= reg_wdata[PDP_POLARITY_BIT];
        end
        PDP_ADDR_VOLUME: playback_volume_code <= reg_wdata[7:0];
        PDP_ADDR_LIM_ONE: begin
          limiter_enable <= reg_wdata[PDP_LIM_ENABLE_BIT];
          limiter_decay_code <= reg_wdata[PDP_DCY_LSB +: 4];
          limiter_attack_code <= reg_wdata[PDP_ATK_LSB +: 4];
        end
        PDP_ADDR_LIM_TWO: begin
          limiter_threshold_code <= reg_wdata[PDP_LVL_LSB +: 3];
          limiter_boost_code <= reg_wdata[PDP_BOOST_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Readback lags the address by one cycle; unmapped addresses read zero.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 9'h000;
    end else begin
      case (reg_addr)
        PDP_ADDR_POWER_ONE: reg_rdata <= {8'h00, playback_enable};
        PDP_ADDR_CONTROL: reg_rdata <= {2'h0, soft_mute_bit, 3'h0, zero_run_mute_enable,
          1'b0, output_polarity_invert};
        PDP_ADDR_VOLUME: reg_rdata <= {1'b0, playback_volume_code};
        PDP_ADDR_LIM_ONE: reg_rdata <= {limiter_enable, limiter_decay_code,
          limiter_attack_code};
        PDP_ADDR_LIM_TWO: reg_rdata <= {2'h0, limiter_threshold_code, limiter_boost_code};
        default: reg_rdata <= 9'h000;
      endcase
    end
  end

  pdp_serial_rx u_rx (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(playback_enable),
    .frame_start(frame_start),
    .bit_valid(bit_valid),
    .playback_serial_data(playback_serial_data),
    .sample_valid(rx_valid),
    .sample(rx_sample)
  );

  // Stage A: capture the sample, step the soft mute ramp, count zero runs.
  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable) begin
      a_valid <= 1'b0;
      x_reg <= 24'h000000;
    end else begin
      a_valid <= rx_valid;
      if (rx_valid) begin
        x_reg <= rx_sample;
      end
    end
  end

  // One volume step per sample keeps the ramp click-free at any sample rate.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_vol <= PDP_VOL_RESET;
    end else if (rx_valid && playback_enable) begin
      if (soft_mute_bit && cur_vol != 8'h00) begin
        cur_vol <= 8'(cur_vol - 8'h01);
      end else if (!soft_mute_bit && cur_vol < playback_volume_code) begin
        cur_vol <= 8'(cur_vol + 8'h01);
      end else if (!soft_mute_bit && cur_vol > playback_volume_code) begin
        cur_vol <= 8'(cur_vol - 8'h01);
      end
    end
  end

  // Zero-run detector; the mute applies to the 1024th zero sample itself.
  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable || !zero_run_mute_enable) begin
      zero_cnt <= 11'h000;
      zero_run_muted <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sample != 24'h000000) begin
        zero_cnt <= 11'h000;
        zero_run_muted <= 1'b0;
      end else if (zero_cnt != PDP_ZERO_RUN) begin
        zero_cnt <= 11'(zero_cnt + 11'h001);
        zero_run_muted <= (11'(zero_cnt + 11'h001) == PDP_ZERO_RUN);
      end
    end
  end

  // Gain from volume, limiter reduction and boost, all in half-dB steps.
  logic [3:0] boost_eff;
  logic [9:0] gain_att, gain_shift_w, gain_frac_w;
  logic [5:0] shamt;
  logic signed [40:0] prod, scaled;
  logic [23:0] y_sat, y_mag, y_pol;
  assign boost_eff = (limiter_boost_code > PDP_BOOST_MAX) ? PDP_BOOST_MAX
    : limiter_boost_code;
  assign gain_att = PDP_GAIN_OFFSET - {2'h0, cur_vol} + {4'h0, lim_att[17:12]}
    - {5'h00, boost_eff, 1'b0};
  assign gain_shift_w = gain_att / PDP_STEPS_PER_SHIFT;
  assign gain_frac_w = gain_att % PDP_STEPS_PER_SHIFT;
  assign shamt = 6'(PDP_GAIN_SHIFT_BASE + gain_shift_w[5:0]);
  assign prod = $signed(x_reg) * $signed({1'b0, PDP_MANT[gain_frac_w[3:0]]});
  assign scaled = prod >>> shamt;
  assign y_sat = (scaled[40:23] == {18{scaled[40]}}) ? scaled[23:0]
    : (scaled[40] ? 24'h800000 : 24'h7FFFFF);
  assign y_mag = y_sat[23] ? 24'(~y_sat + 24'h000001) : y_sat;
  // Negating full negative scale would wrap, so it saturates instead.
  assign y_pol = !output_polarity_invert ? y_sat
    : ((y_sat == 24'h800000) ? 24'h7FFFFF : 24'(~y_sat + 24'h000001));

  // Stage B: processed sample, muted on code zero or a long zero run.
  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable) begin
      out_valid <= 1'b0;
      out_sample <= 24'h000000;
    end else begin
      out_valid <= a_valid;
      if (a_valid) begin
        out_sample <= (cur_vol == 8'h00 || zero_run_muted) ? 24'h000000 : y_pol;
      end
    end
  end

  // Limiter: attack above the upper threshold, decay below the lower, hold between.
  logic [2:0] lvl_eff;
  logic [3:0] atk_eff, dcy_eff;
  logic [17:0] atk_step, dcy_step;
  logic [18:0] att_up;
  logic above_upper, below_lower;
  assign lvl_eff = (limiter_threshold_code > PDP_LVL_CODE_MAX) ? PDP_LVL_CODE_MAX
    : limiter_threshold_code;
  assign above_upper = y_mag > PDP_LIM_THR[lvl_eff];
  assign below_lower = y_mag < PDP_LIM_THR[3'(lvl_eff + 3'h1)];
  assign atk_eff = (limiter_attack_code > PDP_RATE_CODE_MAX) ? PDP_RATE_CODE_MAX
    : limiter_attack_code;
  assign dcy_eff = (limiter_decay_code > PDP_RATE_CODE_MAX) ? PDP_RATE_CODE_MAX
    : limiter_decay_code;
  assign atk_step = PDP_LIM_ATK_RATE >> atk_eff;
  // The slowest decay codes shift the rate to nothing; one LSB keeps the gain recovering.
  assign dcy_step = ((PDP_LIM_DCY_RATE >> dcy_eff) == 18'h00000) ? 18'h00001
    : (PDP_LIM_DCY_RATE >> dcy_eff);
  assign att_up = {1'b0, lim_att} + {1'b0, atk_step};

  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable || !limiter_enable) begin
      lim_att <= 18'h00000;
    end else if (a_valid) begin
      if (above_upper) begin
        lim_att <= (att_up > {1'b0, PDP_LIM_ATT_MAX}) ? PDP_LIM_ATT_MAX
          : att_up[17:0];
      end else if (below_lower) begin
        lim_att <= (lim_att > dcy_step) ? 18'(lim_att - dcy_step) : 18'h00000;
      end
    end
  end

  // Status flag trails the limiter state by one cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      limiter_active <= 1'b0;
      path_running <= 1'b0;
    end else begin
      limiter_active <= (lim_att != 18'h00000);
      path_running <= playback_enable;
    end
  end

  // Linear interpolation over 64 ticks; the last tick lands exactly on the target.
  logic [29:0] interp_delta;
  assign interp_delta = 30'($signed({out_sample, 6'h00} - interp) >>> PDP_OSR_LOG2);
  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable) begin
      interp <= 30'h00000000;
      interp_step <= 30'h00000000;
      step_cnt <= 7'h00;
    end else if (out_valid) begin
      interp_step <= interp_delta;
      step_cnt <= PDP_OSR;
    end else if (oversample_tick && step_cnt != 7'h00) begin
      interp <= (step_cnt == 7'h01) ? {out_sample, 6'h00} : 30'(interp + interp_step);
      step_cnt <= 7'(step_cnt - 7'h01);
    end
  end

  // First-order error feedback in offset binary gives 17 output levels.
  logic [24:0] sd_sum;
  assign sd_sum = {1'b0, interp[29:6] ^ 24'h800000} + {5'h00, sd_err};
  always_ff @(posedge ref_clk) begin
    if (reset || !playback_enable) begin
      dac_level <= PDP_DAC_MID;
      sd_err <= 20'h00000;
    end else if (oversample_tick) begin
      dac_level <= sd_sum[24:20];
      sd_err <= sd_sum[19:0];
    end
  end

  a_disabled_idle: assert property (@(posedge ref_clk) disable iff (reset)
    !playback_enable |=> dac_level == PDP_DAC_MID && !out_valid)
    else $error("path active while disabled");
  a_vol_zero_mute: assert property (@(posedge ref_clk) disable iff (reset)
    playback_enable && a_valid && cur_vol == 8'h00 |=> out_sample == 24'h000000)
    else $error("volume code zero did not mute");
  a_soft_ramp_down: assert property (@(posedge ref_clk) disable iff (reset)
    rx_valid && playback_enable && soft_mute_bit && cur_vol != 8'h00
    |=> cur_vol == 8'($past(cur_vol) - 8'h01))
    else $error("soft mute did not step down by one");
  a_zero_run_mute: assert property (@(posedge ref_clk) disable iff (reset)
    rx_valid && playback_enable && zero_run_mute_enable && rx_sample == 24'h000000
    && zero_cnt == 11'h3FF ##1 zero_run_mute_enable && playback_enable |-> zero_run_muted)
    else $error("no mute after 1024 zeros");
  a_zero_run_release: assert property (@(posedge ref_clk) disable iff (reset)
    rx_valid && rx_sample != 24'h000000 |=> !zero_run_muted && zero_cnt == 11'h000)
    else $error("nonzero sample did not release mute");
  a_automute_off: assert property (@(posedge ref_clk) disable iff (reset)
    !zero_run_mute_enable |=> !zero_run_muted && zero_cnt == 11'h000)
    else $error("auto mute acted while disabled");
  a_limiter_off: assert property (@(posedge ref_clk) disable iff (reset)
    !limiter_enable |=> lim_att == 18'h00000)
    else $error("limiter reduced gain while disabled");
  a_limiter_attack: assert property (@(posedge ref_clk) disable iff (reset)
    playback_enable && limiter_enable && a_valid && above_upper
    && lim_att < PDP_LIM_ATT_MAX ##1 limiter_enable && playback_enable
    |-> lim_att > $past(lim_att)) else $error("limiter did not attack");
  a_limiter_decay: assert property (@(posedge ref_clk) disable iff (reset)
    playback_enable && limiter_enable && a_valid && below_lower && lim_att != 18'h00000
    ##1 limiter_enable && playback_enable |-> lim_att < $past(lim_att))
    else $error("limiter did not decay");
  c_limiter_engaged: cover property (@(posedge ref_clk) disable iff (reset)
    limiter_enable && a_valid && above_upper);
  c_zero_run_muted: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(zero_run_muted));
  c_soft_mute_done: cover property (@(posedge ref_clk) disable iff (reset)
    soft_mute_bit && cur_vol == 8'h00);
endmodule
`default_nettype wire

// ### src/pdp_serial_rx.sv
// Serial sample receiver: shifts 24 bits MSB first into one playback sample.
// Assumes bit strobes and frame marks are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module pdp_serial_rx
  import pdp_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Path enable.
  input wire logic enable,
  // Serial input.
  input wire logic frame_start,
  input wire logic bit_valid,
  input wire logic playback_serial_data,
  // Parallel sample.
  output logic sample_valid,
  output logic [23:0] sample
);
  logic [4:0] bit_cnt;
  logic in_word;
  logic [23:0] shift;

  // Shift bits until 24 are in; bits past the word wait for the next frame mark.
  always_ff @(posedge ref_clk) begin
    if (reset || !enable) begin
      bit_cnt <= 5'h00;
      in_word <= 1'b0;
      shift <= 24'h000000;
      sample_valid <= 1'b0;
      sample <= 24'h000000;
    end else begin
      sample_valid <= 1'b0;
      if (bit_valid && (frame_start || in_word)) begin
        shift <= {shift[22:0], playback_serial_data};
        if (frame_start) begin
          bit_cnt <= 5'h01;
          in_word <= 1'b1;
        end else if (bit_cnt == PDP_SAMPLE_LAST_BIT) begin
          in_word <= 1'b0;
          sample_valid <= 1'b1;
          sample <= {shift[22:0], playback_serial_data};
        end else begin
          bit_cnt <= 5'(bit_cnt + 5'h01);
        end
      end
    end
  end

  a_rx_word_done: assert property (@(posedge ref_clk) disable iff (reset)
    enable && bit_valid && in_word && !frame_start && bit_cnt == PDP_SAMPLE_LAST_BIT
    |=> sample_valid) else $error("24th bit did not complete a sample");
endmodule
`default_nettype wire

// ### testbench/pdp_audio_source.sv
// Model of the audio interface host that feeds playback samples serially.
// Assumes the bench calls send_word from one thread, one word after another.
`timescale 1ns/100ps
`default_nettype none
module pdp_audio_source (
  // Clock.
  input wire logic ref_clk,
  // Serial output towards the playback path.
  output logic frame_start,
  output logic bit_valid,
  output logic playback_serial_data
);
  // Quiet line at time zero, so nothing is taken during reset.
  initial begin
    frame_start = 1'b0;
    bit_valid = 1'b0;
    playback_serial_data = 1'b0;
  end

  // One 24-bit two's complement word, MSB first with its frame mark.
  // After the word the data line shows the inverse of the last bit.
  // A stale copy would let a receiver that reads past the word pass by luck.
  task automatic send_word(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(posedge ref_clk);
      frame_start <= (i == 23);
      bit_valid <= 1'b1;
      playback_serial_data <= word[i];
    end
    @(posedge ref_clk);
    frame_start <= 1'b0;
    bit_valid <= 1'b0;
    playback_serial_data <= ~word[0];
  endtask
endmodule
`default_nettype wire

// ### testbench/pdp_playback_path_test.sv
// Self-checking bench of the playback path: register port, levels, auto mute, limiter.
// Assumes the register map of pdp_pkg and a tick every fourth clock from the bench.
`timescale 1ns/100ps
`default_nettype none
module pdp_playback_path_test
  import pdp_pkg::*;
;
  logic ref_clk, reset, reg_write, frame_start, bit_valid;
  logic oversample_tick = 1'b0;
  logic playback_serial_data, path_running, zero_run_muted, limiter_active;
  logic [6:0] reg_addr;
  logic [8:0] reg_wdata, reg_rdata;
  logic [4:0] dac_level;
  logic [1:0] tick_cnt = 2'h0;
  int error_cnt, n_tests;
  localparam logic [6:0] ADDRS [6] = '{7'h03, 7'h0A, 7'h0B, 7'h18, 7'h19, 7'h05};
  localparam logic [8:0] RSTS [6] = '{9'h000, 9'h000, 9'h0FF, 9'h032, 9'h000, 9'h000};
  localparam logic [8:0] ONES [6] = '{9'h001, 9'h045, 9'h0FF, 9'h1FF, 9'h07F, 9'h000};
  // Limiter cases: threshold and boost word, enable, expected activity.
  localparam logic [8:0] LIM2 [9] = '{9'h050, 9'h050, 9'h000, 9'h010, 9'h030, 9'h070,
    9'h004, 9'h002, 9'h00D};
  localparam logic LIMON [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic LIMEXP [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  pdp_playback_path dut_u (.ref_clk(ref_clk), .reset(reset), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .bit_valid(bit_valid),
    .playback_serial_data(playback_serial_data), .oversample_tick(oversample_tick),
    .dac_level(dac_level), .path_running(path_running), .zero_run_muted(zero_run_muted),
    .limiter_active(limiter_active));

  pdp_audio_source src_u (.ref_clk(ref_clk), .frame_start(frame_start),
    .bit_valid(bit_valid), .playback_serial_data(playback_serial_data));

  // Free-running clock of 10 ns.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Oversampling tick every fourth clock, far faster than a real clock manager.
  always @(posedge ref_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    oversample_tick <= (tick_cnt == 2'h3);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One-cycle write strobe; the design takes it at the second edge.
  task automatic reg_wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  // Read data is registered: one edge to present the address, one to capture.
  task automatic reg_rd(input logic [6:0] a, input logic [8:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    check($sformatf("reg %0h", a), {23'h0, reg_rdata}, {23'h0, exp});
  endtask

  // Sends n copies of a word, then lets the processing pipeline settle.
  task automatic send(input logic [23:0] w, input int n);
    repeat (n) src_u.send_word(w);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Sums dac_level over 64 ticks after the interpolator has reached its target.
  task automatic level_in(input string what, input int lo, input int hi);
    integer sum;
    sum = 0;
    repeat (300) @(posedge ref_clk);
    repeat (256) begin
      @(posedge ref_clk);
      #1;
      if (oversample_tick === 1'b1) sum += dac_level;
    end
    check(what, {31'h0, (sum >= lo) && (sum <= hi)}, 32'h1);
  endtask

  // Guard against a hang anywhere in the main sequence.
  initial begin
    #980000;
    error_cnt++;
    $display("[ERR] run time expected done seen timeout");
    test_done();
  end

  // Main sequence; levels are sums of 64 ticks, mid code 8 gives 512.
  initial begin
    error_cnt = 0;
    n_tests = 0;
    reset = 1'b1;
    reg_write = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    check("idle level", dac_level, 5'h08);
    check("running", path_running, 1'b0);
    check("muted", zero_run_muted, 1'b0);
    check("limiting", limiter_active, 1'b0);
    for (int i = 0; i < 6; i++) reg_rd(ADDRS[i], RSTS[i]);
    for (int i = 0; i < 6; i++) begin
      reg_wr(ADDRS[i], 9'h1FF);
      reg_rd(ADDRS[i], ONES[i]);
      reg_wr(ADDRS[i], RSTS[i]);
    end
    send(24'h400000, 4);
    level_in("disabled level", 512, 512);
    reg_wr(7'h03, 9'h001);
    @(posedge ref_clk);
    #1;
    check("running", path_running, 1'b1);
    send(24'h400000, 8);
    level_in("unity level", 717, 819);
    reg_wr(7'h0A, 9'h001);
    send(24'h400000, 8);
    level_in("inverted level", 205, 307);
    reg_wr(7'h0A, 9'h000);
    reg_wr(7'h0B, 9'h0F3);
    send(24'h400000, 20);
    level_in("minus 6 dB level", 589, 691);
    reg_wr(7'h0B, 9'h000);
    send(24'h400000, 260);
    level_in("code 0 level", 486, 538);
    reg_wr(7'h0B, 9'h0FF);
    send(24'h400000, 260);
    reg_wr(7'h0A, 9'h040);
    send(24'h400000, 5);
    level_in("ramp start level", 653, 819);
    send(24'h400000, 260);
    level_in("soft muted level", 486, 538);
    reg_wr(7'h0A, 9'h000);
    send(24'h400000, 260);
    level_in("restored level", 717, 819);
    reg_wr(7'h0A, 9'h004);
    send(24'h000000, 1023);
    check("muted", zero_run_muted, 1'b0);
    send(24'h000000, 1);
    check("muted", zero_run_muted, 1'b1);
    send(24'h400000, 1);
    check("muted", zero_run_muted, 1'b0);
    send(24'h000000, 1023);
    check("muted", zero_run_muted, 1'b0);
    send(24'h000000, 1);
    check("muted", zero_run_muted, 1'b1);
    reg_wr(7'h0A, 9'h000);
    send(24'h000000, 1);
    check("muted", zero_run_muted, 1'b0);
    for (int i = 0; i < 9; i++) begin
      reg_wr(7'h03, 9'h000);
      reg_wr(7'h19, LIM2[i]);
      reg_wr(7'h18, {LIMON[i], 8'h00});
      reg_wr(7'h03, 9'h001);
      send(24'h5A0000, 20);
      check("limiting", limiter_active, LIMEXP[i]);
    end
    reg_wr(7'h19, 9'h000);
    for (int i = 0; i < 300 && limiter_active !== 1'b0; i++) send(24'h5A0000, 1);
    check("limiting", limiter_active, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
